// ### design/crpa_pkg.sv
/*
 Constants, types and field layout of the CMOS RAM and real-time clock port block.
 Assumes a single 40 MHz system clock and I/O requests from logic on that clock.
*/
// Function
// - Internal clock select high serves lower pair here; low forwards to external chip.
// - Lower port pair reaches only the first 128 CMOS bytes.
// - Lower data port reads and writes the byte chosen by lower index.
// - Upper index port holds a full 8-bit index, reset zero.
// - Upper data port reads and writes the byte chosen by upper index.
// - Upper port pair is decoded only while its access enable is one.
// - Upper pair reaches all 256 bytes even when lower pair is external.
// - Clock registers at 00-0D; 0E-FF, 7D-7F included, are plain storage.
// - Time byte order, ranges, 12-hour afternoon bit and 24-hour range.
// - Control A: update in progress, divider select 010 runs, periodic rate.
// - Control B bits 6:4 enable periodic, alarm and update-done interrupts.
// - Control B: update inhibit, spare bit, binary format, hour format, daylight saving; no daylight saving change is made, that bit is only stored.
// - Register D bit 7 reads battery good, bits 6:0 zero.
// - Lower index holds 7-bit index; bit 7 is NMI disable, reset one.
package crpa_pkg;
   localparam logic [7:0]  PORT_LO_IDX     = 8'h70;
   localparam logic [7:0]  PORT_LO_DAT     = 8'h71;
   localparam logic [7:0]  PORT_UP_IDX     = 8'h74;
   localparam logic [7:0]  PORT_UP_DAT     = 8'h75;
   localparam logic [7:0]  OFS_SEC         = 8'h00;
   localparam logic [7:0]  OFS_SEC_ALM     = 8'h01;
   localparam logic [7:0]  OFS_MIN         = 8'h02;
   localparam logic [7:0]  OFS_MIN_ALM     = 8'h03;
   localparam logic [7:0]  OFS_HOUR        = 8'h04;
   localparam logic [7:0]  OFS_HOUR_ALM    = 8'h05;
   localparam logic [7:0]  OFS_WEEKDAY     = 8'h06;
   localparam logic [7:0]  OFS_DAY         = 8'h07;
   localparam logic [7:0]  OFS_MONTH       = 8'h08;
   localparam logic [7:0]  OFS_YEAR        = 8'h09;
   localparam logic [7:0]  OFS_CTL_A       = 8'h0A;
   localparam logic [7:0]  OFS_CTL_B       = 8'h0B;
   localparam logic [7:0]  OFS_FLAGS_C     = 8'h0C;
   localparam logic [7:0]  OFS_BATTERY_D   = 8'h0D;
   localparam logic [7:0]  OFS_DATE_ALM    = 8'h7D;
   localparam logic [7:0]  OFS_MONTH_ALM   = 8'h7E;
   localparam logic [7:0]  OFS_CENTURY     = 8'h7F;
   localparam int          NUM_TIME        = 10;
   localparam int          B_UIP           = 7;
   localparam int          B_SET           = 7;
   localparam int          B_BIN           = 2;
   localparam int          B_H24           = 1;
   localparam logic [2:0]  DIV_RUN         = 3'h2;
   localparam logic [7:0]  LO_IDX_RST      = 8'h80;
   localparam logic [7:0]  UP_IDX_RST      = 8'h00;
   localparam logic [7:0]  CTL_A_RST       = 8'h00;
   localparam logic [7:0]  CTL_B_RST       = 8'h00;
   localparam logic [7:0]  ALM_DONT_CARE   = 8'hC0;
   localparam int          CLK_PERIOD_NS   = 25;
   localparam int          TICK_PERIOD_NS  = 30517;
   localparam int          TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [14:0] UIP_START       = 15'h7FF8;
   localparam logic [14:0] DIV_LAST        = 15'h7FFF;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } crpa_io_req_s;
endpackage

// ### design/crpa_ram.sv
/*
 Plain byte storage of the CMOS space, 256 bytes of flip-flops.
 Assumes one write per cycle; the owner decides which offsets land here.
*/
`timescale 1ns/1ps
module crpa_ram
   import crpa_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       we_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] rdata_o
);
   logic [7:0] mem_ff [0:255];

   assign rdata_o = mem_ff[addr_i];

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < 256; i++)
         begin
            mem_ff[i] <= 8'h00;
         end
      end
      else if (we_i)
      begin
         mem_ff[addr_i] <= wdata_i;
      end
   end
endmodule

// ### design/crpa_top.sv
/*
 CMOS RAM with real-time clock behind two index/data I/O port pairs.
 Assumes the host issues one-cycle read/write strobes on the system clock.
*/
`timescale 1ns/1ps
module crpa_top
   import crpa_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)
(
   input  wire logic         CLK_SYS_I,
   input  wire logic         RST_N_I,
   input  crpa_io_req_s      IO_REQ_I,
   input  wire logic         INTERNAL_CLOCK_SELECT_I,
   input  wire logic         UPPER_PORT_ACCESS_ENABLE_I,
   input  wire logic         BATTERY_GOOD_I,
   input  wire logic [7:0]   EXT_RDATA_I,
   output logic      [7:0]   IO_RDATA_O,
   output logic              IO_RVALID_O,
   output crpa_io_req_s      EXT_REQ_O,
   output logic              NMI_DISABLE_O,
   output logic              IRQ_O
);
   function automatic logic [7:0] bin2bcd(input logic [7:0] b);
      logic [7:0] t;
      t = b / 8'h0A;
      return {t[3:0], 4'(b - t * 8'h0A)};
   endfunction

   function automatic logic [7:0] fmt(input logic [7:0] b, input logic bcd);
      return bcd ? bin2bcd(b) : b;
   endfunction

   function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bcd);
      return bcd ? ({4'h0, v[7:4]} * 8'h0A + {4'h0, v[3:0]}) : v;
   endfunction

   // Wrapping increment; carry set on wrap
   function automatic logic [8:0] inc_wrap(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic bcd);
      logic [8:0] r;
      r = {1'b0, v + 8'h01};
      if (v == fmt(hi, bcd))
         r = {1'b1, fmt(lo, bcd)};
      else if (bcd && v[3:0] == 4'h9)
         r = {1'b0, v + 8'h07};
      return r;
   endfunction

   function automatic logic [7:0] days_in(input logic [7:0] m, input logic [7:0] y);
      logic [7:0] d;
      d = 8'h1F;
      if (m == 8'h02)
         d = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
      else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h0B)
         d = 8'h1E;
      return d;
   endfunction

   // 12-hour mode keeps afternoon in bit 7
   function automatic logic [8:0] inc_hour(input logic [7:0] v, input logic h24,
                                           input logic bcd);
      logic [8:0] r;
      logic [8:0] w;
      w = inc_wrap({1'b0, v[6:0]}, 8'h01, 8'h0C, bcd);
      r = {1'b0, v[7], w[6:0]};
      if (h24)
         r = inc_wrap(v, 8'h00, 8'h17, bcd);
      else if ({1'b0, v[6:0]} == fmt(8'h0C, bcd))
         r = {1'b0, v[7], 7'(fmt(8'h01, bcd))};
      else if ({1'b0, v[6:0]} == fmt(8'h0B, bcd))
         r = {v[7], ~v[7], 7'(fmt(8'h0C, bcd))};
      return r;
   endfunction

   function automatic logic alm_hit(input logic [7:0] alm, input logic [7:0] v);
      return ((alm & ALM_DONT_CARE) == ALM_DONT_CARE) || (alm == v);
   endfunction

   logic [7:0]   lidx_ff;
   logic [7:0]   uidx_ff;
   logic [7:0]   ctl_a_ff;
   logic [7:0]   ctl_b_ff;
   logic [2:0]   flg_ff;
   logic [7:0]   tim_ff [0:NUM_TIME-1];
   logic [7:0]   nxt_tim [0:NUM_TIME-1];
   logic [10:0]  pre_ff;
   logic [14:0]  div_ff;
   logic         upd_d_ff;
   logic         bat_s1_ff;
   logic         bat_s2_ff;
   logic         bat_s3_ff;
   logic         bat_ff;
   logic [7:0]   rdata_ff;
   logic         rvalid_ff;
   logic         ext_pend_ff;
   crpa_io_req_s ext_req_ff;
   logic         irq_ff;

   // Port decode
   wire          acc_w     = IO_REQ_I.rd | IO_REQ_I.wr;
   wire          hit_lo_i  = IO_REQ_I.addr == PORT_LO_IDX;
   wire          hit_lo_d  = IO_REQ_I.addr == PORT_LO_DAT;
   wire          hit_up_i  = IO_REQ_I.addr == PORT_UP_IDX;
   wire          hit_up_d  = IO_REQ_I.addr == PORT_UP_DAT;
   wire          fwd       = acc_w & (hit_lo_i | hit_lo_d) & ~INTERNAL_CLOCK_SELECT_I;
   wire          lo_idx_a  = acc_w & hit_lo_i & INTERNAL_CLOCK_SELECT_I;
   wire          lo_dat_a  = acc_w & hit_lo_d & INTERNAL_CLOCK_SELECT_I;
   wire          up_idx_a  = acc_w & hit_up_i & UPPER_PORT_ACCESS_ENABLE_I;
   wire          up_dat_a  = acc_w & hit_up_d & UPPER_PORT_ACCESS_ENABLE_I;
   wire          dat_a     = lo_dat_a | up_dat_a;
   // lower window holds bit 7 low
   wire [7:0]    cmos_addr = up_dat_a ? uidx_ff : {1'b0, lidx_ff[6:0]};
   wire          dat_wr    = dat_a & IO_REQ_I.wr;
   wire          is_rtc    = cmos_addr <= OFS_BATTERY_D;
   wire          ram_we    = dat_wr & ~is_rtc;
   wire          rd_c      = dat_a & IO_REQ_I.rd & (cmos_addr == OFS_FLAGS_C);
   wire [7:0]    ram_rdata;

   // Time base
   wire          bcd       = ~ctl_b_ff[B_BIN];
   wire          run       = ctl_a_ff[6:4] == DIV_RUN;
   wire          tick32    = run & (pre_ff == 11'(TICK_CYC - 1));
   wire          sec_tick  = tick32 & (div_ff == DIV_LAST);
   wire          upd       = sec_tick & ~ctl_b_ff[B_SET];
   wire          update_in_progress       = run & ~ctl_b_ff[B_SET] & (div_ff >= UIP_START);
   wire [3:0]    rs        = ctl_a_ff[3:0];
   wire [3:0]    rsh       = (rs < 4'h3) ? rs + 4'h6 : rs - 4'h1;
   wire [14:0]   rmask     = 15'((16'h0001 << rsh) - 16'h0001);
   wire          pf_evt    = tick32 & (rs != 4'h0) & ((div_ff & rmask) == rmask);
   wire          af_evt    = upd_d_ff & alm_hit(tim_ff[1], tim_ff[0])
                             & alm_hit(tim_ff[3], tim_ff[2]) & alm_hit(tim_ff[5], tim_ff[4]);
   wire [2:0]    evts      = {pf_evt, af_evt, upd_d_ff};
   wire [2:0]    nxt_flg   = (flg_ff & ~{3{rd_c}}) | evts;
   wire          nxt_irq   = |(nxt_flg & ctl_b_ff[6:4]);
   wire [7:0]    reg_c     = {irq_ff, flg_ff, 4'h0};
   wire [7:0]    reg_d     = {bat_ff, 7'h00};
   wire [7:0]    tim_rd    = (cmos_addr < 8'(NUM_TIME)) ? tim_ff[cmos_addr[3:0]] : 8'h00;

   wire [7:0]    cmos_rd   = ~is_rtc                     ? ram_rdata :
                             (cmos_addr == OFS_CTL_A)    ? {update_in_progress, ctl_a_ff[6:0]} :
                             (cmos_addr == OFS_CTL_B)    ? ctl_b_ff :
                             (cmos_addr == OFS_FLAGS_C)  ? reg_c :
                             (cmos_addr == OFS_BATTERY_D) ? reg_d : tim_rd;
   wire [7:0]    nxt_rdata = lo_idx_a ? lidx_ff :
                             up_idx_a ? uidx_ff : cmos_rd;

   crpa_ram u_ram
   (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (RST_N_I),
      .we_i    (ram_we),
      .addr_i  (cmos_addr),
      .wdata_i (IO_REQ_I.wdata),
      .rdata_o (ram_rdata)
   );

   always_comb
   begin
      logic [8:0] s;
      logic [8:0] m;
      logic [8:0] h;
      logic [8:0] d;
      logic [8:0] mo;
      logic [8:0] wd;
      logic [8:0] y;
      logic [7:0] dim;
      s   = inc_wrap(tim_ff[0], 8'h00, 8'h3B, bcd);
      m   = inc_wrap(tim_ff[2], 8'h00, 8'h3B, bcd);
      h   = inc_hour(tim_ff[4], ctl_b_ff[B_H24], bcd);
      wd  = inc_wrap(tim_ff[6], 8'h01, 8'h07, bcd);
      dim = days_in(to_bin(tim_ff[8], bcd), to_bin(tim_ff[9], bcd));
      d   = inc_wrap(tim_ff[7], 8'h01, dim, bcd);
      mo  = inc_wrap(tim_ff[8], 8'h01, 8'h0C, bcd);
      y   = inc_wrap(tim_ff[9], 8'h00, 8'h63, bcd);
      for (int i = 0; i < NUM_TIME; i++)
      begin
         nxt_tim[i] = tim_ff[i];
      end
      if (upd)
      begin
         nxt_tim[0] = s[7:0];
         if (s[8])
         begin
            nxt_tim[2] = m[7:0];
            if (m[8])
            begin
               nxt_tim[4] = h[7:0];
               if (h[8])
               begin
                  nxt_tim[6] = wd[7:0];
                  nxt_tim[7] = d[7:0];
                  if (d[8])
                  begin
                     nxt_tim[8] = mo[7:0];
                     if (mo[8])
                        nxt_tim[9] = y[7:0];
                  end
               end
            end
         end
      end
      // Host write wins over same-cycle update
      if (dat_wr && cmos_addr < 8'(NUM_TIME))
         nxt_tim[cmos_addr[3:0]] = IO_REQ_I.wdata;
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         for (int i = 0; i < NUM_TIME; i++)
         begin
            tim_ff[i] <= 8'h00;
         end
      end
      else
      begin
         tim_ff <= nxt_tim;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         lidx_ff <= LO_IDX_RST;
      else if (acc_w && hit_lo_i && IO_REQ_I.wr)
         lidx_ff <= IO_REQ_I.wdata;
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         uidx_ff <= UP_IDX_RST;
      else if (up_idx_a && IO_REQ_I.wr)
         uidx_ff <= IO_REQ_I.wdata;
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         ctl_a_ff <= CTL_A_RST;
         ctl_b_ff <= CTL_B_RST;
      end
      else if (dat_wr)
      begin
         if (cmos_addr == OFS_CTL_A)
            ctl_a_ff <= {1'b0, IO_REQ_I.wdata[6:0]};
         if (cmos_addr == OFS_CTL_B)
            ctl_b_ff <= IO_REQ_I.wdata;
      end
   end

   // Divider restarts while stopped
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         pre_ff   <= 11'h000;
         div_ff   <= 15'h0000;
         upd_d_ff <= 1'b0;
      end
      else
      begin
         pre_ff   <= (!run || tick32) ? 11'h000 : pre_ff + 11'h001;
         div_ff   <= !run ? 15'h0000 : div_ff + 15'(tick32);
         upd_d_ff <= upd;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         flg_ff <= 3'h0;
         irq_ff <= 1'b0;
      end
      else
      begin
         flg_ff <= nxt_flg;
         irq_ff <= nxt_irq;
      end
   end

   // Pin is asynchronous; third stage must agree
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         bat_s1_ff <= 1'b0;
         bat_s2_ff <= 1'b0;
         bat_s3_ff <= 1'b0;
         bat_ff    <= 1'b0;
      end
      else
      begin
         bat_s1_ff <= BATTERY_GOOD_I;
         bat_s2_ff <= bat_s1_ff;
         bat_s3_ff <= bat_s2_ff;
         if (bat_s2_ff == bat_s3_ff)
            bat_ff <= bat_s3_ff;
      end
   end

   // Host answers; forwarded reads answer a cycle later
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         rdata_ff    <= 8'h00;
         rvalid_ff   <= 1'b0;
         ext_req_ff  <= '0;
         ext_pend_ff <= 1'b0;
      end
      else
      begin
         ext_req_ff  <= fwd ? IO_REQ_I : '0;
         ext_pend_ff <= fwd & IO_REQ_I.rd;
         rvalid_ff   <= ext_pend_ff | (IO_REQ_I.rd & (lo_idx_a | up_idx_a | dat_a));
         if (ext_pend_ff)
            rdata_ff <= EXT_RDATA_I;
         else if (IO_REQ_I.rd && (lo_idx_a || up_idx_a || dat_a))
            rdata_ff <= nxt_rdata;
      end
   end

   assign IO_RDATA_O    = rdata_ff;
   assign IO_RVALID_O   = rvalid_ff;
   assign EXT_REQ_O     = ext_req_ff;
   assign NMI_DISABLE_O = lidx_ff[7];
   assign IRQ_O         = irq_ff;

   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RST_N_I);

   sequence s_fwd_req;
      fwd && IO_REQ_I.rd;
   endsequence
   sequence s_fwd_ans;
      EXT_REQ_O.rd ##1 IO_RVALID_O;
   endsequence

   a_fwd_lower_read: assert property (s_fwd_req |=> s_fwd_ans)
      else $error("forwarded read not answered");
   a_lower_half_only: assert property (lo_dat_a && IO_REQ_I.wr && !is_rtc
                                       |=> u_ram.mem_ff[$past(lidx_ff[6:0])] == $past(IO_REQ_I.wdata))
      else $error("lower window left first 128 bytes");
   a_lower_data_read: assert property (IO_REQ_I.rd && lo_dat_a && !is_rtc
                                       |=> IO_RDATA_O == $past(ram_rdata))
      else $error("lower data read mismatch");
   a_upper_index_wr: assert property (up_idx_a && IO_REQ_I.wr
                                      |=> uidx_ff == $past(IO_REQ_I.wdata))
      else $error("upper index not written");
   a_upper_port_gate: assert property (IO_REQ_I.rd && hit_up_d && !UPPER_PORT_ACCESS_ENABLE_I
                                       && !ext_pend_ff |=> !IO_RVALID_O)
      else $error("upper port answered while disabled");
   a_upper_when_ext: assert property (IO_REQ_I.rd && up_dat_a && !INTERNAL_CLOCK_SELECT_I
                                      && !ext_pend_ff |=> IO_RVALID_O && !EXT_REQ_O.rd)
      else $error("upper port not served internally");
   a_divider_stop: assert property (ctl_a_ff[6:4] != DIV_RUN ##1 ctl_a_ff[6:4] != DIV_RUN
                                    |-> div_ff == 15'h0000 && !upd_d_ff && !tick32)
      else $error("time advanced with divider stopped");
   a_flags_clear: assert property (rd_c && evts == 3'h0 |=> flg_ff == 3'h0 && !IRQ_O)
      else $error("flags not cleared by read");
   a_battery_read: assert property (IO_REQ_I.rd && dat_a && cmos_addr == OFS_BATTERY_D
                                    |=> IO_RDATA_O == {$past(bat_ff), 7'h00})
      else $error("register D value wrong");
   a_nmi_disable: assert property (acc_w && hit_lo_i && IO_REQ_I.wr
                                   |=> NMI_DISABLE_O == $past(IO_REQ_I.wdata[7]))
      else $error("NMI disable not written");
endmodule

// ### tb/crpa_ext_model.sv
/*
 Model of the external clock chip behind the forwarded lower port pair.
 Assumes forwarded requests arrive as one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
module crpa_ext_model
   import crpa_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  crpa_io_req_s      ext_req_i,
   output logic      [7:0]   ext_rdata_o
);
   logic [7:0] mem [128];
   logic [6:0] idx_ff;
   logic [7:0] last_ff;
   wire        rd_hit = ext_req_i.rd && (ext_req_i.addr == PORT_LO_DAT);

   // Not selected: inverted last value so a stale byte never passes
   assign ext_rdata_o = rd_hit ? mem[idx_ff] : ~last_ff;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         idx_ff  <= 7'h00;
         last_ff <= 8'h00;
      end
      else
      begin
         if (ext_req_i.wr && ext_req_i.addr == PORT_LO_IDX)
            idx_ff <= ext_req_i.wdata[6:0];
         if (ext_req_i.wr && ext_req_i.addr == PORT_LO_DAT)
            mem[idx_ff] <= ext_req_i.wdata;
         if (rd_hit)
            last_ff <= mem[idx_ff];
      end
   end
endmodule

// ### tb/test_crpa_top.sv
/*
 Self-checking bench of the CMOS port block: host port tasks and sequences.
 Assumes the external clock chip model; tick shortened to 2 cycles.
*/
`timescale 1ns/1ps
module test_crpa_top
   import crpa_pkg::*;
;
   logic         clk;
   logic         rst_n;
   crpa_io_req_s req;
   logic         sel;
   logic         upen;
   logic         batt;
   logic [7:0]   ext_rdata;
   logic [7:0]   rdata;
   logic         rvalid;
   crpa_io_req_s ext_req;
   logic         nmi_dis;
   logic         irq;
   int           fails;
   int           checked;
   int           n;

   crpa_top #(.TICK_CYC(2)) u_crpa_top (
      .CLK_SYS_I                  (clk),
      .RST_N_I                    (rst_n),
      .IO_REQ_I                   (req),
      .INTERNAL_CLOCK_SELECT_I    (sel),
      .UPPER_PORT_ACCESS_ENABLE_I (upen),
      .BATTERY_GOOD_I             (batt),
      .EXT_RDATA_I                (ext_rdata),
      .IO_RDATA_O                 (rdata),
      .IO_RVALID_O                (rvalid),
      .EXT_REQ_O                  (ext_req),
      .NMI_DISABLE_O              (nmi_dis),
      .IRQ_O                      (irq)
   );

   crpa_ext_model u_crpa_ext_model (
      .clk_i       (clk),
      .rst_n_i     (rst_n),
      .ext_req_i   (ext_req),
      .ext_rdata_o (ext_rdata)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic stop_test();
      if (fails == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      #1 req = '0;
   endtask

   // Latency 0 internal, 1 forwarded, 4 means no answer
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input int elat);
      int lat;
      @(posedge clk);
      #1 req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1 req = '0;
      lat = 0;
      while (rvalid !== 1'b1 && lat < 4)
      begin
         @(posedge clk);
         #1 lat++;
      end
      chk("answer latency", 8'(lat), 8'(elat));
      if (elat != 4)
         chk("read data", rdata, exp);
   endtask

   task automatic lo_rd(input logic [7:0] i, input logic [7:0] exp);
      wr(PORT_LO_IDX, i);
      rchk(PORT_LO_DAT, exp, 0);
   endtask

   task automatic lo_wr(input logic [7:0] i, input logic [7:0] d);
      wr(PORT_LO_IDX, i);
      wr(PORT_LO_DAT, d);
   endtask

   task automatic up_rd(input logic [7:0] i, input logic [7:0] exp);
      wr(PORT_UP_IDX, i);
      rchk(PORT_UP_DAT, exp, 0);
   endtask

   task automatic up_wr(input logic [7:0] i, input logic [7:0] d);
      wr(PORT_UP_IDX, i);
      wr(PORT_UP_DAT, d);
   endtask

   // Run takes about 66000 cycles; cut off well past that
   initial
   begin
      #(90000 * 25);
      fails++;
      stop_test();
   end

   initial
   begin
      fails = 0;
      checked = 0;
      rst_n = 1'b0;
      req = '0;
      sel = 1'b1;
      upen = 1'b1;
      batt = 1'b1;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("nmi disable", {7'h00, nmi_dis}, 8'h01);
      chk("irq", {7'h00, irq}, 8'h00);
      rchk(PORT_UP_IDX, 8'h00, 0);
      rchk(PORT_UP_DAT, 8'h00, 0);
      lo_wr(8'h10, 8'hA5);
      chk("nmi disable", {7'h00, nmi_dis}, 8'h00);
      lo_rd(8'h90, 8'hA5);
      chk("nmi disable", {7'h00, nmi_dis}, 8'h01);
      lo_wr(8'hA0, 8'h77);
      up_rd(8'h20, 8'h77);
      up_rd(8'hA0, 8'h00);
      up_rd(8'h90, 8'h00);
      up_rd(8'h10, 8'hA5);
      rchk(8'h72, 8'h00, 4);
      up_wr(8'hC3, 8'h5A);
      up_rd(8'hC3, 8'h5A);
      upen = 1'b0;
      wr(PORT_UP_IDX, 8'h10);
      wr(PORT_UP_DAT, 8'hFF);
      rchk(PORT_UP_DAT, 8'h00, 4);
      rchk(PORT_UP_IDX, 8'h00, 4);
      upen = 1'b1;
      rchk(PORT_UP_IDX, 8'hC3, 0);
      up_rd(8'h10, 8'hA5);
      sel = 1'b0;
      lo_wr(8'h10, 8'h3C);
      rchk(PORT_LO_DAT, 8'h3C, 1);
      up_rd(8'h10, 8'hA5);
      sel = 1'b1;
      rchk(PORT_LO_DAT, 8'hA5, 0);
      for (n = 0; n < 6; n++)
         up_wr(8'(8'h0E + n * 8'h17), 8'(8'h11 * n + 8'h06));
      for (n = 0; n < 6; n++)
         up_rd(8'(8'h0E + n * 8'h17), 8'(8'h11 * n + 8'h06));
      lo_wr(OFS_DATE_ALM, 8'h1F);
      lo_wr(OFS_MONTH_ALM, 8'h0C);
      lo_wr(OFS_CENTURY, 8'h14);
      lo_rd(OFS_DATE_ALM, 8'h1F);
      lo_rd(OFS_MONTH_ALM, 8'h0C);
      lo_rd(OFS_CENTURY, 8'h14);
      lo_rd(OFS_BATTERY_D, 8'h80);
      batt = 1'b0;
      repeat (8) @(posedge clk);
      lo_wr(OFS_BATTERY_D, 8'hFF);
      lo_rd(OFS_BATTERY_D, 8'h00);
      lo_wr(OFS_FLAGS_C, 8'hFF);
      lo_rd(OFS_FLAGS_C, 8'h00);
      // Periodic event every 4 ticks, first masked then enabled
      lo_wr(OFS_CTL_A, 8'h23);
      repeat (20) @(posedge clk);
      #1 chk("irq", {7'h00, irq}, 8'h00);
      lo_rd(OFS_FLAGS_C, 8'h40);
      lo_wr(OFS_CTL_B, 8'h40);
      repeat (20) @(posedge clk);
      #1 chk("irq", {7'h00, irq}, 8'h01);
      lo_rd(OFS_FLAGS_C, 8'hC0);
      // Stop the divider; a last periodic event lands just before the stop
      lo_wr(OFS_CTL_A, 8'h00);
      rchk(PORT_LO_DAT, 8'h00, 0);
      lo_wr(OFS_FLAGS_C, 8'h00);
      rchk(PORT_LO_DAT, 8'hC0, 0);
      rchk(PORT_LO_DAT, 8'h00, 0);
      // Rates off, binary 24-hour, update-done enabled
      lo_wr(OFS_CTL_B, 8'h16);
      lo_wr(OFS_SEC, 8'h3B);
      lo_wr(OFS_MIN, 8'h05);
      lo_wr(OFS_CTL_A, 8'h20);
      n = 0;
      while (irq !== 1'b1 && n < 70000)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk("update irq", {7'h00, irq}, 8'h01);
      lo_rd(OFS_CTL_A, 8'h20);
      lo_rd(OFS_SEC, 8'h00);
      lo_rd(OFS_MIN, 8'h06);
      lo_rd(OFS_CTL_B, 8'h16);
      lo_rd(OFS_FLAGS_C, 8'h90);
      rchk(PORT_LO_DAT, 8'h00, 0);
      chk("irq", {7'h00, irq}, 8'h00);
      stop_test();
   end
endmodule
